// file: src/prescaled_reload_timer.sv
// Prescaled reload timer with its APB register file and interrupt.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module prescaled_reload_timer #(
    parameter int SRC_DIVIDE = prt_pkg::SRC_DIVIDE
) (
    // Clock and reset.
    input  wire logic                        clock,
    input  wire logic                        rstn,
    // APB slave.
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [prt_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // External pulse input and pulse output.
    input  wire logic                        eventIn,
    output logic                             pulseOut,
    // Interrupt.
    output logic                             irq
);
    import prt_pkg::*;

    if (SRC_DIVIDE < 1) begin : g_check
        $error("prescaled_reload_timer: SRC_DIVIDE must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic              start;
        logic              status;
        logic              edgeFlag;
        logic              undFlag;
        mode_t             mode;
        logic              activeHigh;
        logic [1:0]        irqStatus;
        logic [1:0]        irqMask;
        logic              pulseOut;
        logic [DATA_W-1:0] capture;
        logic              inPrev;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              irq;
    } timer_t;

    timer_t            st;
    timer_t            next_st;

    logic              srcTick;
    logic [DATA_W-1:0] presCount;
    logic [DATA_W-1:0] presReload;
    logic              presUnder;
    logic [DATA_W-1:0] tmrCount;
    logic [DATA_W-1:0] tmrReload;
    logic              tmrUnder;
    logic              setup;
    logic              wr;
    logic              ctrlWr;
    logic              presWr;
    logic              tmrWr;
    logic              forceStop;
    logic              activeLevel;
    logic              rise;
    logic              fall;
    logic              measMode;
    logic              measEnd;
    logic              presStep;
    logic [31:0]       readData;

    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        case (addr)
            ADDR_CTRL, ADDR_PRES, ADDR_TIMER,
            ADDR_MODE, ADDR_IRQ_STAT, ADDR_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////

    // Writes take effect at the edge that completes the access phase.
    assign setup  = psel && !penable;
    assign wr     = psel && penable && st.pready && pwrite && mapped(paddr);
    assign ctrlWr = wr && (paddr == ADDR_CTRL);
    assign presWr = wr && (paddr == ADDR_PRES);
    assign tmrWr  = wr && (paddr == ADDR_TIMER);
    assign forceStop = ctrlWr && pwdata[CTRL_STOP];

    // The input is already synchronous; edges are judged against the
    // active level chosen by the polarity bit.
    assign activeLevel = (eventIn == st.activeHigh);
    assign rise = activeLevel && !st.inPrev;
    assign fall = !activeLevel && st.inPrev;
    assign measMode = (st.mode == MODE_WIDTH) || (st.mode == MODE_PERIOD);

    always_comb begin
        case (st.mode)
            MODE_TIMER:     presStep = srcTick;
            MODE_PULSE_OUT: presStep = srcTick;
            MODE_EVENT:     presStep = rise;
            MODE_WIDTH:     presStep = srcTick && activeLevel;
            MODE_PERIOD:    presStep = srcTick;
            default:        presStep = 1'b0;
        endcase
        presStep = presStep && st.status && !forceStop;
    end

    // A width measurement ends when the active level is left; a period
    // measurement ends at the next active edge.
    assign measEnd = st.status && !forceStop
        && (((st.mode == MODE_WIDTH) && fall) || ((st.mode == MODE_PERIOD) && rise));

    ////////////////////////////////////////////////////////////////////////////

    count_source_divider #(
        .DIVIDE      (SRC_DIVIDE)
    ) u_divider (
        .clock       (clock),
        .rstn        (rstn),
        .tick        (srcTick)
    );

    // The prescaler steps the timer on every prescaler underflow.
    reload_stage #(
        .WIDTH       (DATA_W),
        .RESET_VALUE (STAGE_RESET)
    ) u_prescaler (
        .clock       (clock),
        .rstn        (rstn),
        .write       (presWr),
        .writeData   (pwdata[DATA_W-1:0]),
        .running     (st.status),
        .step        (presStep),
        .restart     (measEnd),
        .restore     (forceStop),
        .count       (presCount),
        .reloadValue (presReload),
        .underflow   (presUnder)
    );

    reload_stage #(
        .WIDTH       (DATA_W),
        .RESET_VALUE (STAGE_RESET)
    ) u_timer (
        .clock       (clock),
        .rstn        (rstn),
        .write       (tmrWr),
        .writeData   (pwdata[DATA_W-1:0]),
        .running     (st.status),
        .step        (presUnder),
        .restart     (measEnd),
        .restore     (forceStop),
        .count       (tmrCount),
        .reloadValue (tmrReload),
        .underflow   (tmrUnder)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        case (paddr)
            ADDR_CTRL: begin
                readData = 32'h0000_0000;
                readData[CTRL_START]  = st.start;
                readData[CTRL_STATUS] = st.status;
                readData[CTRL_EDGE]   = st.edgeFlag;
                readData[CTRL_UNDER]  = st.undFlag;
            end
            ADDR_PRES:     readData = {24'h00_0000, presCount};
            ADDR_TIMER:    readData = {24'h00_0000, measMode ? st.capture : tmrCount};
            ADDR_MODE:     readData = {27'h000_0000, st.activeHigh, 1'b0, st.mode};
            ADDR_IRQ_STAT: readData = {30'h0000_0000, st.irqStatus};
            ADDR_IRQ_MASK: readData = {30'h0000_0000, st.irqMask};
            default:       readData = 32'h0000_0000;
        endcase
    end

    // Software clears come first so an event in the same cycle wins.
    always_comb begin
        next_st = st;
        next_st.inPrev = activeLevel;
        next_st.pready = setup;
        next_st.pslverr = setup && !mapped(paddr);
        if (setup) begin
            next_st.prdata = readData;
        end
        if (ctrlWr) begin
            next_st.start = pwdata[CTRL_START];
            if (!pwdata[CTRL_EDGE]) begin
                next_st.edgeFlag = 1'b0;
            end
            if (!pwdata[CTRL_UNDER]) begin
                next_st.undFlag = 1'b0;
            end
        end
        if (wr && (paddr == ADDR_MODE)) begin
            next_st.mode = mode_t'(pwdata[2:0]);
            next_st.activeHigh = pwdata[MODE_POL];
        end
        if (wr && (paddr == ADDR_IRQ_STAT)) begin
            next_st.irqStatus = st.irqStatus & ~pwdata[1:0];
        end
        if (wr && (paddr == ADDR_IRQ_MASK)) begin
            next_st.irqMask = pwdata[1:0];
        end
        if (srcTick) begin
            next_st.status = next_st.start;
        end
        if (forceStop) begin
            next_st.start = 1'b0;
            next_st.status = 1'b0;
        end
        if (measEnd) begin
            next_st.edgeFlag = 1'b1;
            next_st.capture = tmrCount;
            next_st.irqStatus[IRQ_EDGE] = 1'b1;
        end
        if (tmrUnder) begin
            next_st.undFlag = 1'b1;
            next_st.irqStatus[IRQ_UNDER] = 1'b1;
            if (st.mode == MODE_PULSE_OUT) begin
                next_st.pulseOut = !st.pulseOut;
            end
        end
        next_st.irq = |(next_st.irqStatus & next_st.irqMask);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.mode <= MODE_TIMER;
            st.irqMask <= MASK_RESET;
            {st.undFlag, st.edgeFlag, st.status, st.start} <= CTRL_RESET[3:0];
        end else begin
            st <= next_st;
        end
    end

    assign prdata   = st.prdata;
    assign pready   = st.pready;
    assign pslverr  = st.pslverr;
    assign pulseOut = st.pulseOut;
    assign irq      = st.irq;

    ////////////////////////////////////////////////////////////////////////////

    logic irqStatusUnder;
    assign irqStatusUnder = st.irqStatus[IRQ_UNDER];

    default clocking cb @(posedge clock);
    endclocking

    default disable iff (!rstn);

    sequence setupPhase;
        psel && !penable;
    endsequence

    sequence accessReady;
        pready && psel && penable;
    endsequence

    chk_apb_answer: assert property (setupPhase ##1 (psel && penable) |-> accessReady)
        else $error("APB access phase did not see pready");

    chk_start_write: assert property (ctrlWr && !pwdata[CTRL_STOP] |=>
        st.start == $past(pwdata[CTRL_START]))
        else $error("Start bit did not take the written value");

    chk_status_drop: assert property (st.status && !st.start && srcTick && !ctrlWr
        |=> !st.status)
        else $error("Count status stayed set after a stop");

    chk_forced_stop: assert property (forceStop |=> !st.start && !st.status
        && presCount == STAGE_RESET && tmrCount == STAGE_RESET)
        else $error("Forced stop did not restore the stages");

    chk_ctrl_reserved: assert property ((setupPhase and (paddr == ADDR_CTRL))
        |=> prdata[CTRL_STOP] == 1'b0 && prdata[3] == 1'b0 && prdata[7:6] == 2'h0)
        else $error("Forced-stop or unused control bits read non-zero");

    chk_pulse_toggle: assert property (tmrUnder && st.mode == MODE_PULSE_OUT
        |=> pulseOut != $past(pulseOut))
        else $error("Pulse output did not toggle on underflow");

    chk_under_flag: assert property (tmrUnder |=> st.undFlag && irqStatusUnder)
        else $error("Underflow flag not set after underflow");

    chk_edge_flag: assert property (measEnd |=> st.edgeFlag
        && st.capture == $past(tmrCount))
        else $error("Measurement end did not set the edge flag");

    chk_flag_keep: assert property (ctrlWr && pwdata[CTRL_UNDER] && st.undFlag
        |=> st.undFlag)
        else $error("Writing one cleared the underflow flag");

    chk_timer_reload: assert property (tmrUnder && !tmrWr
        |=> tmrCount == $past(tmrReload))
        else $error("Timer did not reload after underflow");

endmodule : prescaled_reload_timer

// file: include/prt_pkg.sv
// Constants, register map and mode codes of the prescaled reload timer.
package prt_pkg;

    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 8;

    localparam logic [11:0] ADDR_CTRL     = 12'h100;
    localparam logic [11:0] ADDR_PRES     = 12'h104;
    localparam logic [11:0] ADDR_TIMER    = 12'h108;
    localparam logic [11:0] ADDR_MODE     = 12'h10c;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h110;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h114;

    localparam int          CTRL_START    = 0;
    localparam int          CTRL_STATUS   = 1;
    localparam int          CTRL_STOP     = 2;
    localparam int          CTRL_EDGE     = 4;
    localparam int          CTRL_UNDER    = 5;
    localparam int          MODE_POL      = 4;
    localparam int          IRQ_UNDER     = 0;
    localparam int          IRQ_EDGE      = 1;

    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  STAGE_RESET   = 8'hff;
    localparam logic [1:0]  MASK_RESET    = 2'h0;

    localparam int          CLOCK_NS      = 10;
    localparam int          SRC_PERIOD_NS = 80;
    localparam int          SRC_DIVIDE    = SRC_PERIOD_NS / CLOCK_NS;

    typedef enum logic [2:0] {
        MODE_TIMER     = 3'h0,
        MODE_PULSE_OUT = 3'h1,
        MODE_EVENT     = 3'h2,
        MODE_WIDTH     = 3'h3,
        MODE_PERIOD    = 3'h4
    } mode_t;

endpackage : prt_pkg

// file: src/count_source_divider.sv
// Divider that makes the internal count source as a one-cycle enable pulse.
`timescale 1ns/100ps
module count_source_divider #(
    parameter int DIVIDE = prt_pkg::SRC_DIVIDE
) (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic rstn,
    // Count source enable.
    output logic      tick
);
    import prt_pkg::*;

    localparam int CW = $clog2(DIVIDE + 1);

    if (DIVIDE < 1) begin : g_check
        $error("count_source_divider: DIVIDE must be at least 1");
    end

    typedef struct packed {
        logic [CW-1:0] count;
        logic          tick;
    } div_t;

    div_t st;
    div_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = (st.count == CW'(DIVIDE - 1));
        if (next_st.tick) begin
            next_st.count = '0;
        end else begin
            next_st.count = st.count + CW'(1);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule : count_source_divider

// file: src/reload_stage.sv
// One down-counting stage: a reload register and a counter behind one address.
`timescale 1ns/100ps
module reload_stage #(
    parameter int               WIDTH       = prt_pkg::DATA_W,
    parameter logic [WIDTH-1:0] RESET_VALUE = prt_pkg::STAGE_RESET
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             rstn,
    // Software write and control.
    input  wire logic             write,
    input  wire logic [WIDTH-1:0] writeData,
    input  wire logic             running,
    input  wire logic             step,
    input  wire logic             restart,
    input  wire logic             restore,
    // Stage state.
    output logic      [WIDTH-1:0] count,
    output logic      [WIDTH-1:0] reloadValue,
    output logic                  underflow
);
    import prt_pkg::*;

    if (WIDTH < 1 || WIDTH > 32) begin : g_check
        $error("reload_stage: WIDTH must lie between 1 and 32");
    end

    typedef struct packed {
        logic [WIDTH-1:0] reloadValue;
        logic [WIDTH-1:0] count;
    } stage_t;

    stage_t st;
    stage_t next_st;

    // A write while running lands in the reload register only; the counter
    // picks it up at its next underflow or restart, whichever comes first.
    always_comb begin
        next_st = st;
        if (restore) begin
            next_st.reloadValue = RESET_VALUE;
            next_st.count = RESET_VALUE;
        end else begin
            if (write) begin
                next_st.reloadValue = writeData;
                if (!running) begin
                    next_st.count = writeData;
                end
            end
            if (restart) begin
                next_st.count = next_st.reloadValue;
            end else if (step) begin
                if (st.count == '0) begin
                    next_st.count = next_st.reloadValue;
                end else begin
                    next_st.count = st.count - WIDTH'(1);
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= {RESET_VALUE, RESET_VALUE};
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign reloadValue = st.reloadValue;
    assign underflow = step && !restart && !restore && (st.count == '0);

endmodule : reload_stage

// file: testbench/pulse_source_model.sv
// Model of the external pulse source that feeds the timer's event input.
`timescale 1ns/100ps
module pulse_source_model (
    // Clock.
    input  wire logic clock,
    // Pulse line, pulled low while idle.
    output logic      eventIn
);
    initial begin
        eventIn = 1'b0;
    end

    // Sends n pulses; each pulse is held high for hi and then low for lo whole clock cycles.
    task automatic sendPulses(input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            eventIn <= 1'b1;
            repeat (hi) @(posedge clock);
            eventIn <= 1'b0;
            repeat (lo) @(posedge clock);
        end
    endtask : sendPulses
endmodule : pulse_source_model

// file: testbench/prescaled_reload_timer_tb.sv
// Self-checking testbench of the prescaled reload timer.
`timescale 1ns/100ps
module prescaled_reload_timer_tb;
    import prt_pkg::*;
    localparam int DIV   = 2;
    localparam int LIMIT = 6000;
    logic        clock, rstn, psel, penable, pwrite, pready, pslverr, eventIn, pulseOut, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err;
    int          errors, num_checks, cycles, n;

    prescaled_reload_timer #(.SRC_DIVIDE(DIV)) prescaled_reload_timer_inst (
        .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .eventIn(eventIn), .pulseOut(pulseOut), .irq(irq));
    pulse_source_model pulse_source_model_inst (.clock(clock), .eventIn(eventIn));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        num_checks++;
        if (seen !== expected) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    // One APB transfer; pready, read data and error are taken at the completing rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        check(rd & m, e);
    endtask : rdChk

    // Counts cycles until pulseOut changes, giving up after 200.
    task automatic waitToggle(output int cnt);
        logic v;
        v   = pulseOut;
        cnt = 0;
        while (pulseOut === v && cnt < 200) begin
            @(negedge clock);
            cnt++;
        end
    endtask : waitToggle

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    task automatic testReset;
        rdChk(ADDR_CTRL, 32'hffffffff, 32'h0);
        rdChk(ADDR_PRES, 32'hffffffff, 32'hff);
        rdChk(ADDR_TIMER, 32'hffffffff, 32'hff);
        apb(1'b0, 12'h0f0, 8'h00);
        check(32'(err), 32'h1);
        check(32'(irq), 32'h0);
        $display("Test reset finished");
    endtask : testReset

    task automatic testTimer;
        wr(ADDR_PRES, 8'h01);
        wr(ADDR_TIMER, 8'h02);
        rdChk(ADDR_TIMER, 32'hff, 32'h02);
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        repeat (2 * DIV) @(posedge clock);
        rdChk(ADDR_CTRL, 32'h0b, 32'h03);
        n = 0;
        do begin
            apb(1'b0, ADDR_CTRL, 8'h00);
            n++;
        end while (rd[CTRL_UNDER] !== 1'b1 && n < 20);
        check(32'(rd[CTRL_UNDER]), 32'h1);
        check(32'(irq), 32'h0);
        wr(ADDR_IRQ_MASK, 8'h03);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h1);
        rdChk(ADDR_IRQ_STAT, 32'h1, 32'h1);
        wr(ADDR_CTRL, 8'h20);
        repeat (2 * DIV) @(posedge clock);
        rdChk(ADDR_CTRL, 32'hff, 32'h20);
        wr(ADDR_CTRL, 8'h00);
        rdChk(ADDR_CTRL, 32'hff, 32'h00);
        wr(ADDR_IRQ_STAT, 8'h03);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h0);
        $display("Test timer finished");
    endtask : testTimer

    task automatic testPulse;
        wr(ADDR_MODE, 8'(MODE_PULSE_OUT));
        wr(ADDR_PRES, 8'h01);
        wr(ADDR_TIMER, 8'h02);
        wr(ADDR_CTRL, 8'h01);
        waitToggle(n);
        waitToggle(n);
        check(32'(n), 32'(2 * 3 * DIV));
        wr(ADDR_CTRL, 8'h05);
        rdChk(ADDR_CTRL, 32'h07, 32'h00);
        rdChk(ADDR_PRES, 32'hff, 32'hff);
        rdChk(ADDR_TIMER, 32'hff, 32'hff);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_IRQ_STAT, 8'h03);
        $display("Test pulse output finished");
    endtask : testPulse

    task automatic testEvent;
        wr(ADDR_MODE, 8'(MODE_EVENT) | 8'h10);
        wr(ADDR_PRES, 8'h03);
        wr(ADDR_CTRL, 8'h01);
        repeat (2 * DIV) @(posedge clock);
        pulse_source_model_inst.sendPulses(2, 2, 2);
        rdChk(ADDR_PRES, 32'hff, 32'h01);
        repeat (20) @(posedge clock);
        rdChk(ADDR_PRES, 32'hff, 32'h01);
        wr(ADDR_CTRL, 8'h04);
        $display("Test event finished");
    endtask : testEvent

    task automatic testMeasure(input mode_t m);
        wr(ADDR_MODE, 8'(m) | 8'h10);
        wr(ADDR_CTRL, 8'h01);
        repeat (2 * DIV) @(posedge clock);
        rdChk(ADDR_CTRL, 32'h10, 32'h00);
        pulse_source_model_inst.sendPulses(2, 3, 3);
        repeat (3) @(posedge clock);
        rdChk(ADDR_CTRL, 32'h10, 32'h10);
        check(32'(irq), 32'h1);
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_CTRL, 8'h00);
        rdChk(ADDR_CTRL, 32'h10, 32'h00);
        wr(ADDR_IRQ_STAT, 8'h03);
        $display("Test measurement finished");
    endtask : testMeasure

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        rstn    = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        testReset();
        testTimer();
        testPulse();
        testEvent();
        testMeasure(MODE_WIDTH);
        testMeasure(MODE_PERIOD);
        tally_and_finish();
    end
endmodule : prescaled_reload_timer_tb
